/* File: logic/scd_consts.vh */
`ifndef SCD_CONSTS_VH
`define SCD_CONSTS_VH

// register byte offsets
`define SCD_OFS_STATUS 12'h050
`define SCD_OFS_PRIMARY 12'h060
`define SCD_OFS_EXTENDED 12'h070
`define SCD_OFS_GATE 12'h100
`define SCD_OFS_DSLP 12'h144

// primary_clock_config fields
`define SCD_PRI_MAIN_CRYSTAL_OSCILLATOR_DIS 0
`define SCD_PRI_INTERNAL_RC_OSCILLATOR_DIS 1
`define SCD_PRI_SRC_LO 4
`define SCD_PRI_SRC_HI 5
`define SCD_PRI_CRYSTAL_SELECT_FIELD_LO 6
`define SCD_PRI_CRYSTAL_SELECT_FIELD_HI 10
`define SCD_PRI_SKIP 11
`define SCD_PRI_PWRDN 13
`define SCD_PRI_PWM_DIVISOR_FIELD_LO 17
`define SCD_PRI_PWM_DIVISOR_FIELD_HI 19
`define SCD_PRI_USEPWM 20
`define SCD_PRI_DIV_LO 23
`define SCD_PRI_DIV_HI 26
`define SCD_PRI_RESET 32'h07802b91

// extended_clock_config fields
`define SCD_EXT_SRC_LO 4
`define SCD_EXT_SRC_HI 6
`define SCD_EXT_SKIP 11
`define SCD_EXT_PWRDN 13
`define SCD_EXT_DIV_LO 23
`define SCD_EXT_DIV_HI 28
`define SCD_EXT_OVR 31
`define SCD_EXT_RESET 32'h07802810

// deep_sleep_clock_config fields
`define SCD_DSL_SRC_LO 4
`define SCD_DSL_SRC_HI 6
`define SCD_DSL_DIV_LO 23
`define SCD_DSL_DIV_HI 28
`define SCD_DSL_RESET 32'h07800010

// source select codes
`define SCD_SRC_MAIN 3'h0
`define SCD_SRC_INT 3'h1
`define SCD_SRC_INT_DIV4 3'h2
`define SCD_SRC_INT30K 3'h3
`define SCD_SRC_RTC 3'h7

// pll relock count in main oscillator cycles
`define SCD_PLL_LOCK_COUNT 13'h1200

`endif

/* File: logic/scd_clock_control.v */
//------------------------------------------------------------
// How it works
//------------------------------------------------------------
// How it works
// - core clock runs from internal oscillator during and after reset.
// - selector also offers pll output and internal oscillator divided by four.
// - with pll skipped, codes 0..3 pick main, internal, internal/4, 30 kHz.
// - pll skipped and extended source 0x7 picks the real-time oscillator.
// - only main oscillator feeds the pll, with skip 0 and source 0.
// - extended register fields replace primary fields while override is on.
// - override enable bit in extended register decides the override.
// - pwm clock is a synchronous division of core clock by pwm divisor.
// - every peripheral clock has its own gate on the core clock.
// - skip bit chooses whether pll or oscillator gets divided.
// - pll path halves the vco before the divisor.
// - division ratio is divisor encoding plus one.
// - skipped pll divides by two for code 0; divisor resets to 0xf.
// - registers hold sleep sources, pll choice, enables, divisors, crystal.
// - deep sleep may take source and divisor from its own register.
// - pll used only after 0x1200 main oscillator cycles of relock.
// - extended divisor is two bits wider, up to divide by 64.
//
// Our own choices: the APB register port and the register offsets.
`timescale 1ns/10ps
`include "scd_consts.vh"

module scd_clock_control #(
  parameter NUM_PERIPH = 8
) (
  // apb slave
  input wire pclk,
  input wire presetn,
  input wire [11:0] paddr,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  // raw clock sources and mode
  input wire main_osc_in,
  input wire int_osc_in,
  input wire int30k_osc_in,
  input wire rtc_osc_in,
  input wire pll_vco_in,
  input wire deep_sleep_in,
  // generated clocks and controls
  output reg core_clock,
  output reg core_tick,
  output reg pwm_tick,
  output reg [NUM_PERIPH-1:0] periph_clock,
  output reg main_osc_enable,
  output reg int_osc_enable,
  output reg pll_enable,
  output reg [4:0] crystal_select,
  output reg pll_ready
);

  //------------------------------------------------------------
  // input synchronisers
  //------------------------------------------------------------
  reg [5:0] sync1_r;
  reg [5:0] sync2_r;
  reg [5:0] prev_r;
  // each raw source is a level here; a rise seen after two flops counts one source cycle
  wire [5:0] rise = sync2_r & ~prev_r;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1_r <= 6'h00;
      sync2_r <= 6'h00;
      prev_r <= 6'h00;
    end else begin
      sync1_r <= {deep_sleep_in, pll_vco_in, rtc_osc_in, int30k_osc_in, int_osc_in, main_osc_in};
      sync2_r <= sync1_r;
      prev_r <= sync2_r;
    end
  end

  wire main_rise = rise[0];
  wire int_rise = rise[1];
  wire slow_rise = rise[2];
  wire rtc_rise = rise[3];
  wire vco_rise = rise[4];
  wire in_deep_sleep = sync2_r[5];

  //------------------------------------------------------------
  // registers
  //------------------------------------------------------------
  reg [31:0] pri_r;
  reg [31:0] ext_r;
  reg [31:0] dsl_r;
  reg [NUM_PERIPH-1:0] gate_r;

  // no wait states: pready always follows the setup cycle by one edge
  wire setup = psel & ~penable;
  wire wr = psel & penable & pready & pwrite;
  wire hit = (paddr == `SCD_OFS_STATUS) || (paddr == `SCD_OFS_PRIMARY) || (paddr == `SCD_OFS_EXTENDED) ||
             (paddr == `SCD_OFS_GATE) || (paddr == `SCD_OFS_DSLP);

  //------------------------------------------------------------
  // read path
  //------------------------------------------------------------
  reg [31:0] rd_nxt;
  reg [2:0] act_src_r;
  reg act_pll_r;
  reg [12:0] lock_cnt_r;
  wire lock_done = (lock_cnt_r == 13'h0000);
  // status: bit 0 pll in use, bits 3:1 active source, bit 4 relock finished
  wire [31:0] status_word = {27'h0000000, lock_done, act_src_r, act_pll_r};

  always @* begin
    rd_nxt = 32'h00000000;
    if (paddr == `SCD_OFS_STATUS) begin
      rd_nxt = status_word;
    end else if (paddr == `SCD_OFS_PRIMARY) begin
      rd_nxt = pri_r;
    end else if (paddr == `SCD_OFS_EXTENDED) begin
      rd_nxt = ext_r;
    end else if (paddr == `SCD_OFS_GATE) begin
      rd_nxt[NUM_PERIPH-1:0] = gate_r;
    end else if (paddr == `SCD_OFS_DSLP) begin
      rd_nxt = dsl_r;
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      prdata <= 32'h00000000;
      pslverr <= 1'b0;
      pri_r <= `SCD_PRI_RESET;
      ext_r <= `SCD_EXT_RESET;
      dsl_r <= `SCD_DSL_RESET;
      gate_r <= {NUM_PERIPH{1'b0}};
    end else begin
      pready <= setup;
      // the error flag stands only beside pready, never past the access cycle
      pslverr <= setup & ~hit;
      if (setup) begin
        prdata <= rd_nxt;
      end
      if (wr) begin
        if (paddr == `SCD_OFS_PRIMARY) begin
          pri_r <= pwdata;
        end else if (paddr == `SCD_OFS_EXTENDED) begin
          ext_r <= pwdata;
        end else if (paddr == `SCD_OFS_GATE) begin
          gate_r <= pwdata[NUM_PERIPH-1:0];
        end else if (paddr == `SCD_OFS_DSLP) begin
          dsl_r <= pwdata;
        end
      end
    end
  end

  //------------------------------------------------------------
  // effective configuration
  //------------------------------------------------------------
  wire ovr = ext_r[`SCD_EXT_OVR];
  // extended fields win over primary fields whenever the override bit is set
  wire eff_skip = ovr ? ext_r[`SCD_EXT_SKIP] : pri_r[`SCD_PRI_SKIP];
  wire eff_pwrdn = ovr ? ext_r[`SCD_EXT_PWRDN] : pri_r[`SCD_PRI_PWRDN];
  wire [2:0] run_src = ovr ? ext_r[`SCD_EXT_SRC_HI:`SCD_EXT_SRC_LO] : {1'b0, pri_r[`SCD_PRI_SRC_HI:`SCD_PRI_SRC_LO]};
  wire [5:0] run_div = ovr ? ext_r[`SCD_EXT_DIV_HI:`SCD_EXT_DIV_LO] : {2'b00, pri_r[`SCD_PRI_DIV_HI:`SCD_PRI_DIV_LO]};
  wire [2:0] eff_src = in_deep_sleep ? dsl_r[`SCD_DSL_SRC_HI:`SCD_DSL_SRC_LO] : run_src;
  wire [5:0] eff_div = in_deep_sleep ? dsl_r[`SCD_DSL_DIV_HI:`SCD_DSL_DIV_LO] : run_div;
  // the pll runs only when the main oscillator is its reference
  wire pll_on = ~eff_pwrdn & (eff_src == `SCD_SRC_MAIN);
  // pll path is held off until the relock count expires
  wire want_pll = ~eff_skip & pll_on & lock_done;

  //------------------------------------------------------------
  // pll relock counter on main oscillator edges
  //------------------------------------------------------------
  // counted in main oscillator edges, so relock time follows the crystal, not pclk
  reg [4:0] crystal_select_field_prev_r;
  reg pll_on_prev_r;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lock_cnt_r <= `SCD_PLL_LOCK_COUNT;
      crystal_select_field_prev_r <= 5'h00;
      pll_on_prev_r <= 1'b0;
    end else begin
      crystal_select_field_prev_r <= pri_r[`SCD_PRI_CRYSTAL_SELECT_FIELD_HI:`SCD_PRI_CRYSTAL_SELECT_FIELD_LO];
      pll_on_prev_r <= pll_on;
      // rewriting the same crystal value does not restart the count
      if ((crystal_select_field_prev_r != pri_r[`SCD_PRI_CRYSTAL_SELECT_FIELD_HI:`SCD_PRI_CRYSTAL_SELECT_FIELD_LO]) || (pll_on & ~pll_on_prev_r) || !pll_on) begin
        lock_cnt_r <= `SCD_PLL_LOCK_COUNT;
      end else if (main_rise && lock_cnt_r != 13'h0000) begin
        lock_cnt_r <= lock_cnt_r - 13'h0001;
      end
    end
  end

  //------------------------------------------------------------
  // source ticks: internal/4 and halved vco
  //------------------------------------------------------------
  // a source faster than pclk/2 loses edges in the synchroniser
  reg [1:0] int_q_r;
  reg vco_half_r;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      int_q_r <= 2'b00;
      vco_half_r <= 1'b0;
    end else begin
      if (int_rise) begin
        int_q_r <= int_q_r + 2'b01;
      end
      if (vco_rise) begin
        vco_half_r <= ~vco_half_r;
      end
    end
  end

  reg src_tick;
  always @* begin
    src_tick = 1'b0;
    if (act_pll_r) begin
      src_tick = vco_rise & vco_half_r;
    end else begin
      case (act_src_r)
        `SCD_SRC_MAIN: src_tick = main_rise;
        `SCD_SRC_INT: src_tick = int_rise;
        `SCD_SRC_INT_DIV4: src_tick = int_rise & (int_q_r == 2'b11);
        `SCD_SRC_INT30K: src_tick = slow_rise;
        `SCD_SRC_RTC: src_tick = rtc_rise;
        default: src_tick = int_rise;
      endcase
    end
  end

  //------------------------------------------------------------
  // core divider, reconfigured only at period end
  //------------------------------------------------------------
  reg [5:0] act_div_r;
  reg [5:0] div_cnt_r;
  reg [2:0] pwm_cnt_r;
  wire period_end = src_tick && (div_cnt_r >= act_div_r);
  // a skipped pll treats code 0 as divide by two
  wire [5:0] next_div = (!want_pll && eff_div == 6'h00) ? 6'h01 : eff_div;
  // summed at seven bits: a divide by 64 would otherwise wrap to zero and never raise core_clock
  wire [6:0] div_len = {1'b0, act_div_r} + 7'h01;
  wire [5:0] half = div_len[6:1];
  wire [5:0] cnt_nxt = src_tick ? (period_end ? 6'h00 : div_cnt_r + 6'h01) : div_cnt_r;
  wire clk_nxt = (cnt_nxt < half);
  wire [2:0] pwm_enc = pri_r[`SCD_PRI_PWM_DIVISOR_FIELD_HI:`SCD_PRI_PWM_DIVISOR_FIELD_LO];
  wire [2:0] pwm_mask = (pwm_enc > 3'h5) ? 3'h7 : (pwm_enc[1] ? 3'h3 : 3'h1);
  wire pwm_hit = ((pwm_cnt_r & pwm_mask) == pwm_mask);

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      act_src_r <= `SCD_SRC_INT;
      act_pll_r <= 1'b0;
      act_div_r <= 6'h0f;
      div_cnt_r <= 6'h00;
      pwm_cnt_r <= 3'h0;
      core_clock <= 1'b0;
      core_tick <= 1'b0;
      pwm_tick <= 1'b0;
      periph_clock <= {NUM_PERIPH{1'b0}};
    end else begin
      div_cnt_r <= cnt_nxt;
      core_clock <= clk_nxt;
      core_tick <= period_end;
      periph_clock <= {NUM_PERIPH{clk_nxt}} & gate_r;
      if (period_end) begin
        act_pll_r <= want_pll;
        act_src_r <= eff_src;
        act_div_r <= next_div;
        pwm_cnt_r <= pwm_cnt_r + 3'h1;
      end
      // unused divisor passes every core period through
      pwm_tick <= period_end & (~pri_r[`SCD_PRI_USEPWM] | pwm_hit);
    end
  end

  //------------------------------------------------------------
  // oscillator and pll control outputs
  //------------------------------------------------------------
  // decoded from the configuration, pll_ready also from the relock count, registered so each pin comes from a flop
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      main_osc_enable <= 1'b0;
      int_osc_enable <= 1'b1;
      pll_enable <= 1'b0;
      crystal_select <= 5'h00;
      pll_ready <= 1'b0;
    end else begin
      main_osc_enable <= ~pri_r[`SCD_PRI_MAIN_CRYSTAL_OSCILLATOR_DIS];
      int_osc_enable <= ~pri_r[`SCD_PRI_INTERNAL_RC_OSCILLATOR_DIS];
      pll_enable <= pll_on;
      crystal_select <= pri_r[`SCD_PRI_CRYSTAL_SELECT_FIELD_HI:`SCD_PRI_CRYSTAL_SELECT_FIELD_LO];
      pll_ready <= pll_on & lock_done;
    end
  end

endmodule // scd_clock_control

/* File: tb/scd_chk_sva.sv */
`timescale 1ns/10ps
//------------------------------------------------------------
// port checker
//------------------------------------------------------------
module scd_chk #(
  parameter NUM_PERIPH = 8
) (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pready,
  input wire pslverr,
  input wire core_clock,
  input wire core_tick,
  input wire pwm_tick,
  input wire [NUM_PERIPH-1:0] periph_clock,
  input wire int_osc_enable,
  input wire pll_enable,
  input wire pll_ready
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  property p_rdy; psel && !penable |=> pready; endproperty
  a_rdy: assert property (p_rdy) else $error("no ready after setup");
  property p_rdy1; pready |=> !pready; endproperty
  a_rdy1: assert property (p_rdy1) else $error("ready held too long");
  property p_err; pslverr |-> pready; endproperty
  a_err: assert property (p_err) else $error("error without ready");
  property p_tick; core_tick |=> !core_tick; endproperty
  a_tick: assert property (p_tick) else $error("core tick too wide");
  property p_pwm; pwm_tick |-> core_tick; endproperty
  a_pwm: assert property (p_pwm) else $error("pwm tick off core period");
  property p_gate; |periph_clock |-> core_clock; endproperty
  a_gate: assert property (p_gate) else $error("peripheral clock without core");
  property p_phase; core_tick |-> core_clock; endproperty
  a_phase: assert property (p_phase) else $error("core period does not start high");
  property p_rst; $rose(presetn) |-> int_osc_enable; endproperty
  a_rst: assert property (p_rst) else $error("internal osc off after reset");
  property p_lock; $rose(pll_ready) |-> pll_enable && $past(pll_enable, 8); endproperty
  a_lock: assert property (p_lock) else $error("pll ready too early");
  property p_off; !pll_enable [*2] |-> !pll_ready; endproperty
  a_off: assert property (p_off) else $error("pll ready while off");
  c_tick: cover property (core_tick);
  c_pwm: cover property (pwm_tick);
  c_err: cover property (pslverr);
  c_lock: cover property ($rose(pll_ready));
endmodule // scd_chk

bind scd_clock_control scd_chk #(.NUM_PERIPH(NUM_PERIPH)) chk_u (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pready(pready), .pslverr(pslverr), .core_clock(core_clock), .core_tick(core_tick),
  .pwm_tick(pwm_tick), .periph_clock(periph_clock), .int_osc_enable(int_osc_enable), .pll_enable(pll_enable),
  .pll_ready(pll_ready));

/* File: tb/scd_testbench.sv */
`timescale 1ns/10ps
`include "scd_consts.vh"
module testbench;
  //------------------------------------------------------------
  // stimulus and checks
  //------------------------------------------------------------
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, dsl = 0;
  logic mo = 0, io = 0, lo = 0, ro = 0, vo = 0;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, r;
  logic pready, pslverr, core_clock, core_tick, pwm_tick, e, moe, ioe, ple, pll_ready;
  logic [4:0] xs;
  logic [7:0] pc, acc;
  int errors = 0, cmp_count = 0, cnt[5], k, n, dv;
  scd_clock_control dut_u (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .main_osc_in(mo),
    .int_osc_in(io), .int30k_osc_in(lo), .rtc_osc_in(ro), .pll_vco_in(vo), .deep_sleep_in(dsl),
    .core_clock(core_clock), .core_tick(core_tick), .pwm_tick(pwm_tick), .periph_clock(pc),
    .main_osc_enable(moe), .int_osc_enable(ioe), .pll_enable(ple), .crystal_select(xs), .pll_ready(pll_ready));
  initial forever #2 pclk = ~pclk;
  int ph = 0;
  // sources step on pclk edges; the design still treats them as unrelated and synchronises them
  always @(posedge pclk) begin
    ph <= ph + 1;
    if (ph % 2 == 0) mo <= ~mo;
    if (ph % 3 == 0) io <= ~io;
    if (ph % 4 == 0) lo <= ~lo;
    if (ph % 5 == 0) ro <= ~ro;
    if (ph % 2 == 1) vo <= ~vo;
  end
  always @(posedge mo) cnt[0]++;
  always @(posedge io) cnt[1]++;
  always @(posedge lo) cnt[2]++;
  always @(posedge ro) cnt[3]++;
  always @(posedge vo) cnt[4]++;
  task complete_run;
    $display("errors=%0d compares=%0d", errors, cmp_count);
    if (errors == 0 && cmp_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task chk(input [31:0] g, input [31:0] x);
    cmp_count++;
    if (g !== x) begin
      errors++;
      $display("mismatch at %0t got %h exp %h", $time, g, x);
    end
  endtask
  task wt(input int s);
    k = 0;
    do @(posedge pclk); while (!(s == 0 ? core_tick : s == 1 ? pwm_tick : pll_ready) && ++k < 30000);
    if (k >= 30000) begin errors++; complete_run; end
  endtask
  task apb(input [11:0] a, input w, input [31:0] d);
    @(posedge pclk);
    psel <= 1; penable <= 0; paddr <= a; pwrite <= w; pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    k = 0;
    do @(posedge pclk); while (pready !== 1'b1 && ++k < 50);
    r = prdata;
    e = pslverr;
    psel <= 0; penable <= 0;
    if (k >= 50) begin errors++; complete_run; end
  endtask
  task rd(input [11:0] a, input [31:0] x, input ex);
    apb(a, 0, 0);
    chk(r, x);
    chk(e, ex);
  endtask
  // source edges counted over one full core period, after the change settles
  task meas(input int s, input int x);
    int c;
    wt(0); wt(0);
    c = cnt[s];
    wt(0);
    chk(cnt[s] - c, x);
  endtask
  function automatic [31:0] pri(input [1:0] s, input [3:0] d, input sk, input pw, input [2:0] m);
    pri = {5'h0, d, 2'h0, pw, m, 3'h0, sk, 1'b0, sk, 5'h0, s, 4'h0};
  endfunction
  initial begin
    void'($urandom(32'h35175ffd));
    repeat (20) @(posedge pclk);
    presetn <= 1;
    rd(`SCD_OFS_PRIMARY, `SCD_PRI_RESET, 0);
    rd(`SCD_OFS_EXTENDED, `SCD_EXT_RESET, 0);
    rd(`SCD_OFS_DSLP, `SCD_DSL_RESET, 0);
    rd(12'h0fc, 0, 1);
    chk(ioe, 1);
    chk(xs, (`SCD_PRI_RESET >> `SCD_PRI_CRYSTAL_SELECT_FIELD_LO) & 32'h1f);
    meas(1, 16);
    apb(`SCD_OFS_PRIMARY, 1, pri(1, 4'hf, 1, 0, 0));
    repeat (20) @(posedge pclk);
    chk(moe, 1);
    for (int s = 0; s < 4; s++) begin
      dv = s == 0 ? 0 : $urandom_range(15, 1);
      n = dv ? dv + 1 : 2;
      apb(`SCD_OFS_PRIMARY, 1, pri(s[1:0], dv[3:0], 1, 0, 0));
      meas(s == 0 ? 0 : s == 3 ? 2 : 1, s == 2 ? 4 * n : n);
    end
    chk(moe, 1);
    for (int i = 0; i < 2; i++) begin
      dv = i ? $urandom_range(62, 1) : 63;
      apb(`SCD_OFS_EXTENDED, 1, {1'b1, 2'h0, dv[5:0], 9'h0, 3'h5, 4'h0, 3'h7, 4'h0});
      meas(3, dv + 1);
    end
    apb(`SCD_OFS_EXTENDED, 1, `SCD_EXT_RESET);
    meas(2, n);
    dv = $urandom_range(63, 1);
    apb(`SCD_OFS_DSLP, 1, {3'h0, dv[5:0], 23'h10});
    dsl <= 1;
    meas(1, dv + 1);
    dsl <= 0;
    for (int m = 0; m < 8; m++) begin
      apb(`SCD_OFS_PRIMARY, 1, pri(1, 1, 1, 1, m[2:0]));
      wt(1); wt(1);
      n = 0;
      do begin wt(0); n++; end while (!pwm_tick && n < 20);
      chk(n, (m == 2 || m == 3) ? 4 : m > 5 ? 8 : 2);
    end
    dv = $urandom_range(254, 1);
    apb(`SCD_OFS_GATE, 1, dv);
    rd(`SCD_OFS_GATE, dv, 0);
    acc = 0;
    repeat (100) begin @(posedge pclk); acc = acc | pc; end
    chk(acc, dv);
    apb(`SCD_OFS_PRIMARY, 1, pri(0, 9, 0, 0, 0));
    chk(pll_ready, 0);
    wt(2);
    chk(k > `SCD_PLL_LOCK_COUNT * 4 - 16, 1);
    chk(k < `SCD_PLL_LOCK_COUNT * 4 + 16, 1);
    chk(ple, 1);
    meas(4, 20);
    rd(`SCD_OFS_STATUS, 32'h00000011, 0);
    complete_run;
  end
endmodule // testbench
